// *** logic/adc_link_pkg.sv ***
// shared constants for the serial converter link
package adc_link_pkg;
  localparam int FRAME_CLOCKS = 16; // clocks in a full frame
  localparam int TRACK_EDGE = 13; // falling edges before return to track
  localparam int LAST_LAUNCH = 15; // falling edge that launches the last bit
  localparam int PD_LOW_EDGE = 2; // first falling edge of power-down window
  localparam int PD_HIGH_EDGE = 10; // falling edge that keeps power
  localparam int SHORT_CLOCKS = 8; // clocks in a power-down burst
  localparam int LEAD_ZEROS = 4; // leading zeros of a frame
  localparam int DEF_RES = 12; // result bits
  localparam int SCLK_HALF = 5; // core cycles per half serial period
  localparam int QUIET_CYCLES = 8; // host quiet gap after release
  localparam int CNT_W = 5; // width of edge counters
  localparam logic [4:0] CNT_ZERO = 5'h00; // counter reset value
endpackage : adc_link_pkg

// *** logic/adc_link_if.sv ***
// link between converter end and host end
`timescale 1ns/100ps
interface adc_link_if;
  logic sclk; // serial clock, made by host
  logic select_n; // active-low frame select, made by host
  logic serial_result_out_o; // data driven by converter
  logic serial_result_out_oe; // high while converter drives data
  logic serial_result_out; // resolved line level
  assign serial_result_out = serial_result_out_oe ? serial_result_out_o : 1'b0;
  modport converter (input sclk, input select_n, output serial_result_out_o,
    output serial_result_out_oe);
  modport host (output sclk, output select_n, input serial_result_out);
endinterface : adc_link_if

// *** logic/sample_fifo.sv ***
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 12, // word width
  parameter int DEPTH = 8 // word count
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic [WIDTH-1:0] in_data, // word in
  input wire logic in_valid, // word offered
  output logic in_ready, // room left
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready // sink takes head
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW:0] wr_reg; // write pointer with wrap bit
  logic [AW:0] rd_reg; // read pointer with wrap bit
  assign in_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
  assign out_valid = wr_reg != rd_reg;
  assign out_data = mem[rd_reg[AW-1:0]];
  // write side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
    end else if (in_valid && in_ready) begin
      wr_reg <= wr_reg + 1'b1;
    end
  end
  // storage has no reset, so it may map to ram
  always_ff @(posedge core_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  // read side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_reg <= '0;
    end else if (out_valid && out_ready) begin
      rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : sample_fifo

// *** logic/adc_converter_end.sv ***
// converter end: serial conversion, readout and power mode control
`timescale 1ns/100ps
module adc_converter_end
  import adc_link_pkg::*;
#(
  parameter int RES_BITS = adc_link_pkg::DEF_RES // 12, 10 or 8
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, high
  adc_link_if.converter link, // serial link pins
  input wire logic [RES_BITS-1:0] sample_value, // analog stand-in, held at sample
  output logic powered_down, // power-down mode
  output logic in_track, // track-and-hold tracking
  output logic converting // conversion in progress
);
  initial begin
    if (RES_BITS != 12 && RES_BITS != 10 && RES_BITS != 8) $error("bad resolution");
  end

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    CONV = 2'b01,
    DONE = 2'b10
  } conv_state_e;

  logic [2:0] sclk_sync; // three-stage sampler of serial clock
  logic [2:0] sel_sync; // three-stage sampler of select
  logic sclk_reg; // accepted serial clock level
  logic sel_reg; // accepted select level
  logic sclk_fall; // accepted falling edge
  logic sclk_rise; // accepted rising edge
  logic sel_fall; // frame start
  logic sel_rise; // frame end
  conv_state_e state_reg; // frame state
  logic [CNT_W-1:0] falls_reg; // falling edges in this frame
  logic [15:0] shift_reg; // frame word being shifted
  logic track_pend_reg; // return to track on next rise

  // frame word: zeros, result msb first, pad zeros
  function automatic logic [15:0] frame_word(input logic [RES_BITS-1:0] v);
    logic [15:0] w;
    w = '0;
    w[15-LEAD_ZEROS -: RES_BITS] = v;
    return w;
  endfunction : frame_word

  // a change counts only once stages two and three agree
  // trade-off: the filter costs about three core cycles per serial edge, so
  // each serial half period must stay well above that latency
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_sync <= 3'h7;
      sel_sync <= 3'h7;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      sel_sync <= {sel_sync[1:0], link.select_n};
    end
  end
  // accepted levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b1;
      sel_reg <= 1'b1;
    end else begin
      if (sclk_sync[1] == sclk_sync[2]) begin
        sclk_reg <= sclk_sync[2];
      end
      if (sel_sync[1] == sel_sync[2]) begin
        sel_reg <= sel_sync[2];
      end
    end
  end
  assign sclk_fall = sclk_reg && sclk_sync[1] == sclk_sync[2] && !sclk_sync[2];
  assign sclk_rise = !sclk_reg && sclk_sync[1] == sclk_sync[2] && sclk_sync[2];
  assign sel_fall = sel_reg && sel_sync[1] == sel_sync[2] && !sel_sync[2];
  assign sel_rise = !sel_reg && sel_sync[1] == sel_sync[2] && sel_sync[2];

  // frame state and edge counter, clocked by core_clk and stepped only by accepted select and serial clock edges
  // DONE waits for select to rise, since select may idle low after a full frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
      falls_reg <= CNT_ZERO;
    end else begin
      case (state_reg)
        IDLE: begin
          if (sel_fall) begin
            state_reg <= CONV;
            falls_reg <= CNT_ZERO;
          end
        end
        CONV: begin
          if (sel_rise) begin
            state_reg <= IDLE;
          end else if (sclk_fall) begin
            falls_reg <= falls_reg + 1'b1;
            if (falls_reg == CNT_W'(FRAME_CLOCKS - 1)) begin
              state_reg <= DONE;
            end
          end
        end
        DONE: begin
          if (sel_rise) begin // select may idle low after a full frame
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // shifter: first zero at select fall, each fall launches next
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (state_reg == IDLE && sel_fall) begin
      shift_reg <= frame_word(sample_value);
    end else if (state_reg == CONV && sclk_fall) begin
      shift_reg <= {shift_reg[14:0], 1'b0};
    end
  end

  // output drive and release
  // the released line reads low on the carrier; after the sixteenth fall
  // no further bit is launched until the next frame starts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.serial_result_out_oe <= 1'b0;
      link.serial_result_out_o <= 1'b0;
    end else if (state_reg == IDLE && sel_fall) begin
      link.serial_result_out_oe <= 1'b1;
      link.serial_result_out_o <= 1'b0;
    end else if (state_reg == CONV && sel_rise) begin
      link.serial_result_out_oe <= 1'b0;
    end else if (state_reg == CONV && sclk_fall) begin
      if (falls_reg == CNT_W'(FRAME_CLOCKS - 1)) begin
        link.serial_result_out_oe <= 1'b0;
      end
      link.serial_result_out_o <= shift_reg[14];
    end
  end

  // track-and-hold: hold at select fall, track after thirteen falls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_track <= 1'b1;
      track_pend_reg <= 1'b0;
    end else if (state_reg == IDLE && sel_fall) begin
      in_track <= 1'b0;
      track_pend_reg <= 1'b0;
    end else if (state_reg != IDLE && sclk_fall
                 && falls_reg == CNT_W'(TRACK_EDGE - 1)) begin
      track_pend_reg <= 1'b1;
    end else if (track_pend_reg && sclk_rise) begin
      in_track <= 1'b1;
      track_pend_reg <= 1'b0;
    end else if (state_reg == CONV && sel_rise) begin
      in_track <= 1'b1; // abort returns to track
    end
  end

  // power mode decided by where select rises
  // a cut with fewer than two falls is taken as a glitch on select and
  // leaves the power mode as it was, so noise on the pin before the second fall cannot move it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      powered_down <= 1'b0;
    end else if (state_reg == CONV && sel_rise) begin
      if (falls_reg >= CNT_W'(PD_HIGH_EDGE)) begin
        powered_down <= 1'b0;
      end else if (falls_reg >= CNT_W'(PD_LOW_EDGE)) begin
        powered_down <= 1'b1;
      end // fewer falls: glitch, mode kept
    end else if (state_reg == CONV && sclk_fall
                 && falls_reg == CNT_W'(PD_HIGH_EDGE - 1)) begin
      powered_down <= 1'b0;
    end
  end

  // busy flag for the user side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      converting <= 1'b0;
    end else begin
      converting <= (state_reg == CONV) && !sel_rise;
    end
  end
endmodule : adc_converter_end

// *** logic/adc_host_end.sv ***
// host end: makes serial clock and select, captures words into a fifo
`timescale 1ns/100ps
module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int RES_BITS = adc_link_pkg::DEF_RES, // result bits
  parameter int FIFO_DEPTH = 8 // buffered words
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, high
  adc_link_if.host link, // serial link pins
  input wire logic start, // pulse: run one frame
  input wire logic short_frame, // with start: 8-clock power-down burst
  output logic busy, // frame or quiet gap running
  output logic [RES_BITS-1:0] result, // head sample
  output logic result_valid, // sample waiting
  input wire logic result_ready // sink takes sample
);
  // the result must fit behind the leading zeros of a sixteen-bit frame
  initial begin
    if (RES_BITS < 1 || RES_BITS > 16 - LEAD_ZEROS) $error("resolution does not fit a frame");
  end
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN = 2'b01,
    H_QUIET = 2'b10
  } host_state_e;

  host_state_e state_reg; // host state
  logic [3:0] div_reg; // half-period divider
  logic [CNT_W-1:0] falls_reg; // falling edges made
  logic [CNT_W-1:0] limit_reg; // clocks in this frame
  logic [15:0] cap_reg; // captured bits
  logic [2:0] din_sync; // data line sampler
  logic word_valid; // full word to fifo
  logic fifo_ready; // fifo has room
  logic [3:0] quiet_reg; // quiet counter
  logic sclk_reg; // driven clock level
  logic sel_reg; // driven select level
  logic [RES_BITS-1:0] fifo_data; // fifo head
  logic fifo_valid; // fifo not empty

  assign link.sclk = sclk_reg;
  assign link.select_n = sel_reg;
  // data line comes back through three flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      din_sync <= 3'h0;
    end else begin
      din_sync <= {din_sync[1:0], link.serial_result_out};
    end
  end

  // frame sequencer: clock idles high, falls first; a full fifo stalls start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= H_IDLE;
      sclk_reg <= 1'b1;
      sel_reg <= 1'b1;
      div_reg <= 4'h0;
      falls_reg <= CNT_ZERO;
      limit_reg <= CNT_ZERO;
      quiet_reg <= 4'h0;
      cap_reg <= 16'h0000;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (start && fifo_ready) begin
            state_reg <= H_RUN;
            sel_reg <= 1'b0;
            div_reg <= 4'h0;
            falls_reg <= CNT_ZERO;
            limit_reg <= short_frame ? CNT_W'(SHORT_CLOCKS) : CNT_W'(FRAME_CLOCKS);
          end
        end
        H_RUN: begin
          if (div_reg == 4'(SCLK_HALF - 1)) begin
            div_reg <= 4'h0;
            if (sclk_reg) begin
              if (falls_reg == limit_reg) begin
                sel_reg <= 1'b1;
                state_reg <= H_QUIET;
                quiet_reg <= 4'h0;
                word_valid <= (limit_reg == CNT_W'(FRAME_CLOCKS));
              end else begin
                sclk_reg <= 1'b0;
                falls_reg <= falls_reg + 1'b1;
                cap_reg <= {cap_reg[14:0], din_sync[2]};
              end
            end else begin
              sclk_reg <= 1'b1;
            end
          end else begin
            div_reg <= div_reg + 1'b1;
          end
        end
        H_QUIET: begin
          if (quiet_reg == 4'(QUIET_CYCLES - 1)) begin
            state_reg <= H_IDLE;
          end else begin
            quiet_reg <= quiet_reg + 1'b1;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // busy flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg != H_IDLE) || (start && fifo_ready);
    end
  end

  sample_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(cap_reg[15-LEAD_ZEROS -: RES_BITS]),
    .in_valid(word_valid),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(result_ready && result_valid)
  );

  // registered view of fifo head; one word in flight
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= fifo_valid && !(result_ready && result_valid);
      result <= fifo_data;
    end
  end
endmodule : adc_host_end

// *** tb/adc_link_properties.sv ***
// concurrent checks on the link between converter end and host end
`timescale 1ns/100ps
module adc_link_properties
  import adc_link_pkg::*;
#(
  parameter int RES_BITS = 12 // result bits
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic sclk, // serial clock
  input wire logic select_n, // frame select, low
  input wire logic serial_result_out_o, // converter data
  input wire logic serial_result_out_oe, // converter enable
  input wire logic serial_result_out // resolved line
);
  logic sclk_reg; // sclk one cycle ago
  logic sel_reg; // select one cycle ago
  logic [4:0] falls_reg; // falls in this frame, kept after it
  logic [4:0] since_reg; // cycles since the last fall
  logic fall_seen; // sclk fell this cycle
  assign fall_seen = sclk_reg && !sclk;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // history of the host's pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_reg <= 1'b1;
      sel_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk;
      sel_reg <= select_n;
    end
  end
  // falls are held past the frame end so the select rise can judge the length
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      falls_reg <= CNT_ZERO;
    end else if (sel_reg && !select_n) begin
      falls_reg <= CNT_ZERO;
    end else if (fall_seen && !select_n) begin
      falls_reg <= falls_reg + 5'h01;
    end
  end
  // saturating gap counter, so a late launch still shows as large
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_reg <= CNT_ZERO;
    end else if (fall_seen) begin
      since_reg <= CNT_ZERO;
    end else if (since_reg != 5'h1F) begin
      since_reg <= since_reg + 5'h01;
    end
  end
  property p_drive_on_fall;
    $fell(select_n) |-> ##[1:6] serial_result_out_oe;
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("line not driven after select fall");
  property p_drive_in_frame;
    !sel_reg && !select_n && falls_reg != 5'h00 && falls_reg < 5'h10 |-> serial_result_out_oe;
  endproperty
  a_drive_in_frame: assert property (p_drive_in_frame)
    else $error("line released inside a frame");
  property p_release_last;
    fall_seen && !select_n && falls_reg == 5'h0F |-> ##[1:6] !serial_result_out_oe;
  endproperty
  a_release_last: assert property (p_release_last)
    else $error("line held after last fall");
  property p_release_rise;
    $rose(select_n) |-> ##[1:6] !serial_result_out_oe;
  endproperty
  a_release_rise: assert property (p_release_rise)
    else $error("line held after select rise");
  property p_lead_zero;
    serial_result_out_oe && falls_reg < 5'h04 |-> !serial_result_out_o;
  endproperty
  a_lead_zero: assert property (p_lead_zero)
    else $error("leading bit not zero");
  property p_pad_zero;
    serial_result_out_oe && int'(falls_reg) > LEAD_ZEROS + RES_BITS |-> !serial_result_out_o;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("pad bit not zero");
  property p_bit_launch;
    serial_result_out_oe && $past(serial_result_out_oe) && $changed(serial_result_out_o)
      |-> since_reg < 5'h07;
  endproperty
  a_bit_launch: assert property (p_bit_launch)
    else $error("data changed away from a falling edge");
  property p_idle_high;
    select_n && $past(select_n) |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("clock not idle high");
  property p_frame_len;
    $rose(select_n) |-> falls_reg == 5'h10 || falls_reg == 5'h08;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length not 16 or 8");
  property p_quiet;
    $rose(select_n) |-> select_n [*8];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet gap too short");
  c_full: cover property ($rose(select_n) && falls_reg == 5'h10);
  c_short: cover property ($rose(select_n) && falls_reg == 5'h08);
  c_drive: cover property ($rose(serial_result_out_oe));
endmodule : adc_link_properties

// *** tb/sar_adc_serial_readout_tb.sv ***
// self-checking bench: both link ends, plus a second converter on a bench-driven link
`timescale 1ns/100ps
module sar_adc_serial_readout_tb;
  import adc_link_pkg::*;
  localparam int RES = 10; // narrow variant, so pad zeros show
  logic core_clk; // core clock
  logic rst; // async reset
  logic [RES-1:0] sample_value; // converter input level
  logic start; // frame request
  logic short_frame; // power-down burst
  logic result_ready; // sink takes word
  logic busy; // host busy
  logic [RES-1:0] result; // head word
  logic result_valid; // word waiting
  logic powered_down; // main converter mode
  logic in_track; // main track state
  logic converting; // main conversion flag
  logic fault_pd; // second converter mode
  int bad_count = 0; // mismatches
  int n_checks = 0; // comparisons
  adc_link_if link_inst(); // link between the two ends
  adc_link_if fault_inst(); // link whose host side is the bench
  adc_converter_end #(.RES_BITS(RES)) adc_converter_end_inst (.core_clk(core_clk), .rst(rst),
    .link(link_inst), .sample_value(sample_value), .powered_down(powered_down),
    .in_track(in_track), .converting(converting));
  adc_host_end #(.RES_BITS(RES), .FIFO_DEPTH(8)) adc_host_end_inst (.core_clk(core_clk),
    .rst(rst), .link(link_inst), .start(start), .short_frame(short_frame), .busy(busy),
    .result(result), .result_valid(result_valid), .result_ready(result_ready));
  adc_converter_end #(.RES_BITS(RES)) adc_converter_end_inst2 (.core_clk(core_clk), .rst(rst),
    .link(fault_inst), .sample_value(sample_value), .powered_down(fault_pd),
    .in_track(), .converting());
  adc_link_properties #(.RES_BITS(RES)) adc_link_properties_inst (.core_clk(core_clk),
    .rst(rst), .sclk(link_inst.sclk), .select_n(link_inst.select_n),
    .serial_result_out_o(link_inst.serial_result_out_o),
    .serial_result_out_oe(link_inst.serial_result_out_oe),
    .serial_result_out(link_inst.serial_result_out));
  // free-running core clock
  always #4 core_clk = ~core_clk;
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // one comparison of a word or flag
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // bounded wait for the host to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge core_clk);
    while (busy !== 1'b0) begin
      n++;
      if (n > 3000) begin
        bad_count++;
        end_of_test();
      end
      @(negedge core_clk);
    end
  endtask : wait_idle
  // one frame request, full or short
  task automatic run(input logic short_f);
    @(negedge core_clk);
    start = 1'b1;
    short_frame = short_f;
    @(negedge core_clk);
    start = 1'b0;
    short_frame = 1'b0;
    wait_idle();
  endtask : run
  // take the head word and compare it
  task automatic pop(input logic [RES-1:0] exp);
    // one edge first, so a word behind a fresh pop has reached the output
    @(negedge core_clk);
    chk("valid", 16'h0001, {15'h0000, result_valid});
    chk("word", {6'h00, exp}, {6'h00, result});
    @(negedge core_clk);
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
  endtask : pop
  // hold mid-frame, back to track once the frame is over
  task automatic t_track();
    sample_value = 10'h2A5;
    @(negedge core_clk);
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (20) @(negedge core_clk);
    chk("track mid", 16'h0000, {15'h0000, in_track});
    chk("conv mid", 16'h0001, {15'h0000, converting});
    wait_idle();
    chk("track end", 16'h0001, {15'h0000, in_track});
    chk("conv end", 16'h0000, {15'h0000, converting});
    pop(10'h2A5);
  endtask : t_track
  // back-to-back words with edge patterns
  task automatic t_words();
    logic [RES-1:0] vals [5];
    vals = '{10'h3FF, 10'h000, 10'h2AA, 10'h155, 10'h201};
    foreach (vals[i]) begin
      sample_value = vals[i];
      run(1'b0);
      pop(vals[i]);
    end
    @(negedge core_clk);
    chk("empty", 16'h0000, {15'h0000, result_valid});
  endtask : t_words
  // short burst powers down, dummy frame wakes, next frame valid
  task automatic t_power();
    sample_value = 10'h0F0;
    run(1'b1);
    chk("pd short", 16'h0001, {15'h0000, powered_down});
    chk("short kept", 16'h0000, {15'h0000, result_valid});
    run(1'b0);
    chk("pd dummy", 16'h0000, {15'h0000, powered_down});
    @(negedge core_clk);
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
    sample_value = 10'h30C;
    run(1'b0);
    pop(10'h30C);
  endtask : t_power
  // fill the buffer with the sink stalled, refuse, then drain in order
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) begin
      sample_value = 10'(i * 37 + 5);
      run(1'b0);
    end
    // a request against a full buffer must not start a frame
    @(negedge core_clk);
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    chk("full busy", 16'h0000, {15'h0000, busy});
    chk("full select", 16'h0001, {15'h0000, link_inst.select_n});
    for (int i = 0; i < 8; i++) begin
      pop(10'(i * 37 + 5));
    end
    @(negedge core_clk);
    chk("drained", 16'h0000, {15'h0000, result_valid});
  endtask : t_fifo
  // bench-made frame of n falls, 80 ns clock, levels changed on core falling edges
  task automatic raw(input int n, input logic exp_pd);
    @(negedge core_clk);
    fault_inst.select_n = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("raw drive", 16'h0001, {15'h0000, fault_inst.serial_result_out_oe});
    repeat (n) begin
      repeat (5) @(negedge core_clk);
      fault_inst.sclk = 1'b0;
      repeat (5) @(negedge core_clk);
      fault_inst.sclk = 1'b1;
    end
    repeat (5) @(negedge core_clk);
    // a full frame has released the line by now, a cut one still drives it
    chk("raw held", (n < 16) ? 16'h0001 : 16'h0000,
      {15'h0000, fault_inst.serial_result_out_oe});
    fault_inst.select_n = 1'b1;
    repeat (12) @(negedge core_clk);
    chk("raw release", 16'h0000, {15'h0000, fault_inst.serial_result_out_oe});
    chk("raw pd", {15'h0000, exp_pd}, {15'h0000, fault_pd});
  endtask : raw
  // cut frames below, inside and above the power window, then a full frame
  task automatic t_fault();
    raw(1, 1'b0);
    raw(5, 1'b1);
    raw(1, 1'b1);
    raw(12, 1'b0);
    raw(16, 1'b0);
  endtask : t_fault
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    sample_value = 10'h000;
    start = 1'b0;
    short_frame = 1'b0;
    result_ready = 1'b0;
    fault_inst.sclk = 1'b1;
    fault_inst.select_n = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    t_track();
    t_words();
    t_power();
    t_fifo();
    t_fault();
    end_of_test();
  end
endmodule : sar_adc_serial_readout_tb
